// File: prom_programmer.sv
`timescale 1ns/1ps
`default_nettype none
`include "prom_prog_params.svh"

// Contract
// R1: Strobe combination selects write, verify, or float
// R2: One byte per program pulse, never page
// R3: Only usable range is programmed and verified
// R4: Addresses above usable range get all-ones
// R5: Byte-by-byte pulse then verify algorithm
// R6: Strobe sequencing like standard byte-wide EPROM
// R7: Verify outside usable range is meaningless
// R8: Retry pulses until match, else write error
module prom_programmer (
  input wire logic CLK, // Clock, 40 MHz
  input wire logic RESETN, // Async reset, active low
  input wire logic REQ_VALID, // Program request pulse
  input wire logic [16:0] REQ_ADDR, // Byte address
  input wire logic [7:0] REQ_DATA, // Byte to program
  output logic BUSY, // Operation in progress
  output logic DONE, // One-cycle completion pulse
  output logic WRITE_ERROR, // With DONE: byte failed
  output logic CHIP_SEL_N, // Chip select to device
  output logic OUT_GATE_N, // Output gate to device
  output logic PROGRAM_STROBE_LOW, // Program strobe to device
  output logic [16:0] PROM_ADDRESS_PINS, // Address to device
  output logic [7:0] PROM_DATA_PINS_O, // Data driven to device
  output logic PROM_DATA_PINS_OE, // High while driving data
  input wire logic [7:0] PROM_DATA_PINS_I // Data read from device
);
  prom_prog_pkg::state_t state;
  prom_prog_pkg::request_t req;
  prom_prog_pkg::strobes_t strb;
  logic [`RETRY_W-1:0] retries;
  logic tmr_load;
  logic [`CNT_W-1:0] tmr_count;
  logic tmr_done;
  logic match;
  logic verify_end;

  function automatic logic [7:0] legal_data(input logic [16:0] a, input logic [7:0] d);
    legal_data = (a > `ADDR_USABLE_HI) ? `FILL_BYTE : d; // [R4]
  endfunction : legal_data

  function automatic logic in_usable(input logic [16:0] a);
    in_usable = (a <= `ADDR_USABLE_HI); // [R3] [R7]
  endfunction : in_usable

  prom_delay_timer u_timer (
    .CLK(CLK),
    .RESETN(RESETN),
    .load(tmr_load),
    .count(tmr_count),
    .expired(tmr_done)
  );

  assign match = (PROM_DATA_PINS_I == req.data);

  // Last cycle of a verify read, where the byte is judged
  assign verify_end = (state == prom_prog_pkg::ST_VERIFY) && tmr_done;

  // Timer reload on every state entry except the return to ST_IDLE
  always_comb begin
    tmr_load = 1'b0;
    tmr_count = 16'h0000;
    case (state)
      prom_prog_pkg::ST_IDLE: begin
        tmr_load = REQ_VALID;
        tmr_count = 16'(`CYC_SETUP);
      end
      prom_prog_pkg::ST_SETUP: begin
        tmr_load = tmr_done;
        tmr_count = 16'(`CYC_PULSE);
      end
      prom_prog_pkg::ST_PULSE: begin
        tmr_load = tmr_done;
        tmr_count = 16'(`CYC_HOLD);
      end
      prom_prog_pkg::ST_HOLD: begin
        tmr_load = tmr_done;
        tmr_count = 16'(`CYC_OE);
      end
      prom_prog_pkg::ST_VERIFY: begin
        tmr_load = tmr_done;
        tmr_count = 16'(`CYC_SETUP);
      end
      prom_prog_pkg::ST_DONE: begin
        tmr_load = 1'b0;
        tmr_count = 16'h0000;
      end
      default: begin
        tmr_load = 1'b0;
        tmr_count = 16'h0000;
      end
    endcase
  end

  // Sequencer: setup, one pulse, hold, verify read, retry [R5] [R6]
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state <= prom_prog_pkg::ST_IDLE;
    end else begin
      case (state)
        prom_prog_pkg::ST_IDLE: begin
          if (REQ_VALID) begin
            state <= prom_prog_pkg::ST_SETUP;
          end
        end
        prom_prog_pkg::ST_SETUP: begin
          if (tmr_done) begin
            state <= prom_prog_pkg::ST_PULSE;
          end
        end
        prom_prog_pkg::ST_PULSE: begin
          if (tmr_done) begin
            state <= prom_prog_pkg::ST_HOLD; // [R2]
          end
        end
        prom_prog_pkg::ST_HOLD: begin
          if (tmr_done) begin
            state <= prom_prog_pkg::ST_VERIFY;
          end
        end
        prom_prog_pkg::ST_VERIFY: begin
          if (tmr_done) begin
            // Count includes the attempt ending now
            if (!in_usable(req.addr) || match || (retries + 5'h01) == `RETRY_MAX) begin
              state <= prom_prog_pkg::ST_DONE; // [R7] [R8]
            end else begin
              state <= prom_prog_pkg::ST_SETUP; // [R8]
            end
          end
        end
        prom_prog_pkg::ST_DONE: begin
          state <= prom_prog_pkg::ST_IDLE;
        end
        default: begin
          state <= prom_prog_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Request capture, fill byte substituted above usable range
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      req <= '0;
    end else if (state == prom_prog_pkg::ST_IDLE && REQ_VALID) begin
      req.addr <= REQ_ADDR;
      req.data <= legal_data(REQ_ADDR, REQ_DATA); // [R4]
    end
  end

  // Pulse counter
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      retries <= 5'h00;
    end else if (state == prom_prog_pkg::ST_IDLE) begin
      retries <= 5'h00;
    end else if (verify_end) begin
      retries <= retries + 5'h01; // [R8]
    end
  end

  // Strobe decode per state [R1] [R6]
  always_comb begin
    strb = '{chip_sel_n: 1'b1, out_gate_n: 1'b1, program_strobe_low: 1'b1};
    case (state)
      prom_prog_pkg::ST_SETUP, prom_prog_pkg::ST_HOLD: begin
        strb.chip_sel_n = 1'b0;
      end
      prom_prog_pkg::ST_PULSE: begin
        strb.chip_sel_n = 1'b0;
        strb.program_strobe_low = 1'b0; // [R1] [R2]
      end
      prom_prog_pkg::ST_VERIFY: begin
        strb.chip_sel_n = 1'b0;
        strb.out_gate_n = 1'b0; // [R1]
      end
      default: begin
        strb = '{chip_sel_n: 1'b1, out_gate_n: 1'b1, program_strobe_low: 1'b1};
      end
    endcase
  end

  // Registered pin drive; data released during verify [R1]
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      CHIP_SEL_N <= 1'b1;
      OUT_GATE_N <= 1'b1;
      PROGRAM_STROBE_LOW <= 1'b1;
      PROM_ADDRESS_PINS <= `ADDR_USABLE_LO;
      PROM_DATA_PINS_O <= `FILL_BYTE;
      PROM_DATA_PINS_OE <= 1'b0;
    end else begin
      CHIP_SEL_N <= strb.chip_sel_n;
      OUT_GATE_N <= strb.out_gate_n;
      PROGRAM_STROBE_LOW <= strb.program_strobe_low;
      PROM_ADDRESS_PINS <= req.addr;
      PROM_DATA_PINS_O <= req.data;
      PROM_DATA_PINS_OE <= (state == prom_prog_pkg::ST_SETUP) ||
                           (state == prom_prog_pkg::ST_PULSE) ||
                           (state == prom_prog_pkg::ST_HOLD);
    end
  end

  // Status outputs
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      BUSY <= 1'b0;
      DONE <= 1'b0;
      WRITE_ERROR <= 1'b0;
    end else begin
      BUSY <= (state != prom_prog_pkg::ST_IDLE) || REQ_VALID;
      DONE <= (state == prom_prog_pkg::ST_DONE);
      if (verify_end) begin
        WRITE_ERROR <= in_usable(req.addr) && !match; // [R8]
      end
    end
  end
endmodule : prom_programmer
`default_nettype wire

// File: prom_prog_params.svh
`ifndef PROM_PROG_PARAMS_SVH
`define PROM_PROG_PARAMS_SVH

`define ADDR_W 17
`define DATA_W 8
`define ADDR_USABLE_LO 17'h0_0000
`define ADDR_USABLE_HI 17'h0_EDFF
`define ADDR_SPACE_TOP 17'h1_FFFF
`define FILL_BYTE 8'hFF
`define CLK_PERIOD_NS 25
// Setup, hold, output delay and pulse width figures in ns
`define T_SETUP_NS 2000
`define T_DATA_HOLD_NS 2000
`define T_OE_DELAY_NS 200
`define T_PULSE_NS 200000
// Least times round up, pulse width rounds down to stay in window
`define CYC_SETUP ((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_HOLD ((`T_DATA_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_OE ((`T_OE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1)
`define CYC_PULSE (`T_PULSE_NS / `CLK_PERIOD_NS)
`define RETRY_MAX 5'h19
`define CNT_W 16
`define RETRY_W 5

`endif

// File: prom_prog_pkg.sv
package prom_prog_pkg;
  // Strobe levels driven to the device, all active low
  typedef struct packed {
    logic chip_sel_n;
    logic out_gate_n;
    logic program_strobe_low;
  } strobes_t;

  typedef struct packed {
    logic [16:0] addr;
    logic [7:0] data;
  } request_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_SETUP = 6'b00_0010,
    ST_PULSE = 6'b00_0100,
    ST_HOLD = 6'b00_1000,
    ST_VERIFY = 6'b01_0000,
    ST_DONE = 6'b10_0000
  } state_t;
endpackage : prom_prog_pkg

// File: prom_delay_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "prom_prog_params.svh"

module prom_delay_timer (
  input wire logic CLK, // Clock
  input wire logic RESETN, // Async reset, active low
  input wire logic load, // Start a new wait
  input wire logic [`CNT_W-1:0] count, // Cycles to wait
  output logic expired // High once the wait is over
);
  logic [`CNT_W-1:0] remaining;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      remaining <= 16'h0000;
    end else if (load) begin
      remaining <= count;
    end else if (remaining != 16'h0000) begin
      remaining <= remaining - 16'h0001;
    end
  end

  // Count only, so callers may derive load from it without a loop
  assign expired = (remaining == 16'h0000);
endmodule : prom_delay_timer
`default_nettype wire

// File: prom_prog_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module prom_prog_asserts (
  input wire logic CLK, // Clock
  input wire logic RESETN, // Reset
  input wire logic DONE, // Done
  input wire logic WRITE_ERROR, // Error
  input wire logic CHIP_SEL_N, // Select
  input wire logic OUT_GATE_N, // Gate
  input wire logic PROGRAM_STROBE_LOW, // Strobe
  input wire logic [16:0] PROM_ADDRESS_PINS, // Address
  input wire logic [7:0] PROM_DATA_PINS_O, // Data out
  input wire logic PROM_DATA_PINS_OE // Drive
);
  logic [15:0] low_cnt;
  logic wr_ready;
  assign wr_ready = PROM_DATA_PINS_OE && !CHIP_SEL_N && OUT_GATE_N;
  // Length of the current program pulse
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      low_cnt <= 16'h0000;
    end else begin
      low_cnt <= PROGRAM_STROBE_LOW ? 16'h0000 : low_cnt + 16'h0001;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  a_no_fight: assert property (
    !(PROM_DATA_PINS_OE && !OUT_GATE_N)) else $error("host drives during read");
  a_pulse_width: assert property (
    $rose(PROGRAM_STROBE_LOW) |-> low_cnt >= 16'h1DB0 && low_cnt <= 16'h20D0)
    else $error("pulse width out of window");
  a_write_setup: assert property (
    $fell(PROGRAM_STROBE_LOW) |-> $past(wr_ready, 79)) else $error("setup too short");
  a_data_hold: assert property (
    $rose(PROGRAM_STROBE_LOW) |-> wr_ready [*8]) else $error("data hold too short");
  a_verify_after: assert property (
    $rose(PROGRAM_STROBE_LOW) |-> ##[80:200] !OUT_GATE_N) else $error("no verify read");
  a_pulse_stable: assert property (
    !PROGRAM_STROBE_LOW && !$past(PROGRAM_STROBE_LOW)
    |-> $stable(PROM_ADDRESS_PINS) && $stable(PROM_DATA_PINS_O))
    else $error("byte changed in pulse");
  a_fill_high: assert property (
    PROM_DATA_PINS_OE && PROM_ADDRESS_PINS > 17'h0_EDFF |-> PROM_DATA_PINS_O == 8'hFF)
    else $error("high area not all ones");
  a_no_err_high: assert property (
    DONE && PROM_ADDRESS_PINS > 17'h0_EDFF |-> !WRITE_ERROR) else $error("error out of range");
endmodule : prom_prog_asserts
bind prom_programmer prom_prog_asserts prom_prog_asserts_i (.CLK, .RESETN, .DONE,
  .WRITE_ERROR, .CHIP_SEL_N, .OUT_GATE_N, .PROGRAM_STROBE_LOW, .PROM_ADDRESS_PINS,
  .PROM_DATA_PINS_O, .PROM_DATA_PINS_OE);
`default_nettype wire

// File: prom_device_model.sv
`timescale 1ns/1ps
`default_nettype none
module prom_device_model (
  input wire logic chip_sel_n, // Select
  input wire logic out_gate_n, // Gate
  input wire logic program_strobe_low, // Strobe
  input wire logic [16:0] addr, // Address
  input wire logic [7:0] data_in, // Data in
  output logic [7:0] data_out // Data out
);
  logic [7:0] mem [0:17'h1_FFFF];
  logic [7:0] last_data = 8'h00;
  int pulses = 0;
  int skip = 0;
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  // One byte per pulse; a skipped pulse models a slow cell
  always @(posedge program_strobe_low) begin
    if (!chip_sel_n && out_gate_n) begin
      pulses++;
      last_data = data_in;
      if (skip > 0) skip--;
      else mem[addr] = mem[addr] & data_in;
    end
  end
  // Released bus shows the inverse of the last byte
  always @* begin
    if (!chip_sel_n && !out_gate_n && program_strobe_low)
      data_out = addr > 17'h0_EDFF ? addr[7:0] ^ 8'hA5 : mem[addr];
    else
      data_out = ~last_data;
  end
endmodule : prom_device_model
`default_nettype wire

// File: prom_programmer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module prom_programmer_tb_top;
  logic clk, resetn, req_valid, busy, done, werr, cs_n, oe_n, pgm_n, data_oe;
  logic [16:0] req_addr, addr_pins;
  logic [7:0] req_data, data_o, data_i, dev_q;
  int failures = 0;
  int n_checks = 0;
  prom_programmer prom_programmer_i (.CLK(clk), .RESETN(resetn), .REQ_VALID(req_valid),
    .REQ_ADDR(req_addr), .REQ_DATA(req_data), .BUSY(busy), .DONE(done), .WRITE_ERROR(werr),
    .CHIP_SEL_N(cs_n), .OUT_GATE_N(oe_n), .PROGRAM_STROBE_LOW(pgm_n),
    .PROM_ADDRESS_PINS(addr_pins), .PROM_DATA_PINS_O(data_o), .PROM_DATA_PINS_OE(data_oe),
    .PROM_DATA_PINS_I(data_i));
  prom_device_model prom_device_model_i (.chip_sel_n(cs_n), .out_gate_n(oe_n),
    .program_strobe_low(pgm_n), .addr(addr_pins), .data_in(data_o), .data_out(dev_q));
  assign data_i = data_oe ? data_o : dev_q;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  // One request; poke issues a second request to 17'h0_0100 while busy, which must be ignored
  task automatic program_byte(input logic [16:0] a, input logic [7:0] d, input bit poke,
      output bit err_seen);
    int n;
    err_seen = 1'b0;
    req_valid = 1'b1;
    req_addr = a;
    req_data = d;
    @(posedge clk);
    #2;
    check("busy", 17'(busy), 17'h0_0001);
    req_valid = poke;
    req_addr = 17'h0_0100;
    n = 0;
    while (done !== 1'b1 && n < 40000) begin
      @(posedge clk);
      #2;
      req_valid = 1'b0;
      if (werr === 1'b1) err_seen = 1'b1;
      n++;
    end
    check("done", 17'(n < 40000), 17'h0_0001);
    @(posedge clk);
    #2;
    check("done_pulse", 17'(done), 17'h0_0000);
    check("busy_end", 17'(busy), 17'h0_0000);
  endtask : program_byte
  task automatic t_low;
    bit e;
    program_byte(17'h0_0000, 8'h5A, 1'b1, e);
    check("err_seen", 17'(e), 17'h0_0000);
    check("mem0", 17'(prom_device_model_i.mem[0]), 17'h0_005A);
    check("pulses", 17'(prom_device_model_i.pulses), 17'h0_0001);
    check("ignored", 17'(prom_device_model_i.mem[17'h0_0100]), 17'h0_00FF);
    check("err", 17'(werr), 17'h0_0000);
  endtask : t_low
  task automatic t_top;
    bit e;
    prom_device_model_i.skip = 1;
    program_byte(17'h0_EDFF, 8'h3C, 1'b0, e);
    check("err_seen", 17'(e), 17'h0_0001);
    check("memtop", 17'(prom_device_model_i.mem[17'h0_EDFF]), 17'h0_003C);
    check("retry", 17'(prom_device_model_i.pulses), 17'h0_0003);
    check("err", 17'(werr), 17'h0_0000);
  endtask : t_top
  task automatic t_high;
    bit e;
    program_byte(17'h0_EE00, 8'h12, 1'b0, e);
    check("err_seen", 17'(e), 17'h0_0000);
    check("fill", 17'(prom_device_model_i.last_data), 17'h0_00FF);
    check("err", 17'(werr), 17'h0_0000);
  endtask : t_high
  initial begin
    resetn = 1'b0;
    req_valid = 1'b0;
    req_addr = 17'h0_0000;
    req_data = 8'h00;
    repeat (8) @(posedge clk);
    #2;
    check("idle", 17'({busy, cs_n, oe_n, pgm_n, data_oe}), 17'h0_000E);
    resetn = 1'b1;
    @(posedge clk);
    #2;
    t_low();
    t_top();
    t_high();
    complete_run();
  end
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    complete_run();
  end
endmodule : prom_programmer_tb_top
`default_nettype wire
